// ===== logic/pdeo_consts.vh
// Bit positions and reset values for the port D/E override logic.
`ifndef PDEO_CONSTS_VH
`define PDEO_CONSTS_VH
`define PDEO_PD_CAPT      0
`define PDEO_PD_EXTIRQ    1
`define PDEO_PE_RXD       0
`define PDEO_PE_TXD       1
`define PDEO_PE_XCK       2
`define PDEO_PE_CMPNEG    3
`define PDEO_PE_SCL       4
`define PDEO_PE_SDA       5
`define PDEO_PE_DO        6
`define PDEO_PE_DIVIDED_CLOCK_OUTPUT      7
`define PDEO_BYTE_ZERO    8'h00
`define PDEO_PAIR_ZERO    2'h0
`define PDEO_BIT_ZERO     1'h0
`define PDEO_BIT_ONE      1'h1
`endif

// ===== logic/pdeo_sync2.v
// Two-flop synchroniser for a vector of pin levels.
`timescale 1ns/1ns
`default_nettype none
`include "pdeo_consts.vh"
module pdeo_sync2 #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;
    // The first stage feeds the second only; metastable values never reach logic.
    always @(posedge clk) begin
        if (rst) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end
    assign q = sync_reg;
endmodule
`default_nettype wire

// ===== logic/pdeo_port_override.v
// Alternate-function override logic for port D bits 1:0 and port E bits 7:0.
`timescale 1ns/1ns
`default_nettype none
`include "pdeo_consts.vh"
module pdeo_port_override (
    input  wire       clk,
    input  wire       rst,
    // Port registers.
    input  wire [1:0] portd_direction,
    input  wire [1:0] portd_output_latch,
    input  wire [7:0] porte_direction,
    input  wire [7:0] porte_output_latch,
    input  wire       global_pullup_disable,
    // Pins.
    input  wire [1:0] portd_pin_in,
    output reg  [1:0] portd_pin_out,
    output reg  [1:0] portd_pin_oe,
    output reg  [1:0] portd_pullup_en,
    input  wire [7:0] porte_pin_in,
    output wire [7:0] porte_pin_out,
    output wire [7:0] porte_pin_oe,
    output reg  [7:0] porte_pullup_en,
    // Peripheral controls.
    input  wire       clock_output_fuse,
    input  wire       divided_clock,
    input  wire       external_irq_zero_enable,
    input  wire       usart_sync_mode,
    input  wire       usart_sync_clock_out,
    input  wire       usart_receiver_enable,
    input  wire       usart_transmitter_enable,
    input  wire       usart_tx_data,
    input  wire       serial_if_twowire_mode,
    input  wire       serial_if_threewire_mode,
    input  wire       serial_if_data_out,
    input  wire       serial_if_sda_low,
    input  wire       serial_if_clock_hold,
    input  wire       comparator_neg_digital_disable,
    input  wire       comparator_pos_digital_disable,
    input  wire [7:0] pin_change_select,
    input  wire       pin_change_group0_enable,
    // Peripheral inputs.
    output wire [1:0] portd_din,
    output wire [7:0] porte_din,
    output wire       external_irq_zero_input,
    output wire       timer1_capture_input,
    output wire       usart_rx_input,
    output wire       usart_sync_clock_in,
    output wire       serial_if_data_in,
    output wire       serial_if_clock_in,
    output wire [7:0] pin_change_source
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    wire [9:0] pins_sync;

    pdeo_sync2 #(
        .W (10)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({portd_pin_in, porte_pin_in}),
        .q   (pins_sync)
    );

    // ------------------------------------------------------------
    // Digital input enables
    // ------------------------------------------------------------
    // Sleep gating is not modelled, so a pin's input is on unless an analog
    // disable takes it and no pin-change keep-on term (pc_keep) holds it on.
    wire [7:0] pc_keep;
    reg  [7:0] porte_die;
    wire [1:0] portd_die;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pc
            assign pc_keep[i] = pin_change_select[i] & pin_change_group0_enable;
        end
    endgenerate

    always @* begin
        porte_die = 8'hFF;
        // The comparator disable wins unless a pin-change source holds it on.
        porte_die[`PDEO_PE_CMPNEG] = pc_keep[`PDEO_PE_CMPNEG] |
                                     ~comparator_neg_digital_disable;
        porte_die[`PDEO_PE_XCK]    = pc_keep[`PDEO_PE_XCK] |
                                     ~comparator_pos_digital_disable;
    end

    assign portd_die = {external_irq_zero_enable | `PDEO_BIT_ONE, `PDEO_BIT_ONE};

    assign portd_din = pins_sync[9:8] & portd_die;
    assign porte_din = pins_sync[7:0] & porte_die;

    assign external_irq_zero_input = portd_din[`PDEO_PD_EXTIRQ];
    assign timer1_capture_input    = portd_din[`PDEO_PD_CAPT];
    assign usart_rx_input          = porte_din[`PDEO_PE_RXD];
    assign usart_sync_clock_in     = porte_din[`PDEO_PE_XCK];
    assign serial_if_data_in       = porte_din[`PDEO_PE_SDA];
    assign serial_if_clock_in      = porte_din[`PDEO_PE_SCL];
    assign pin_change_source       = porte_din;

    // ------------------------------------------------------------
    // Output overrides
    // ------------------------------------------------------------
    reg [7:0] e_out_next;
    reg [7:0] e_oe_next;
    reg [7:0] e_pu_next;
    reg [1:0] d_out_next;
    reg [1:0] d_oe_next;
    reg [1:0] d_pu_next;
    reg       sda_drive_low;
    reg       scl_drive_low;

    always @* begin
        // Plain port behaviour first.
        d_oe_next  = portd_direction;
        d_out_next = portd_output_latch;
        d_pu_next  = portd_output_latch & ~portd_direction & {2{~global_pullup_disable}};
        e_oe_next  = porte_direction;
        e_out_next = porte_output_latch & porte_direction;
        e_pu_next  = porte_output_latch & ~porte_direction & {8{~global_pullup_disable}};

        if (serial_if_threewire_mode) begin
            e_out_next[`PDEO_PE_DO] = serial_if_data_out & porte_direction[`PDEO_PE_DO];
        end

        sda_drive_low = (serial_if_sda_low | ~porte_output_latch[`PDEO_PE_SDA]) &
                        porte_direction[`PDEO_PE_SDA];
        scl_drive_low = (serial_if_clock_hold & ~porte_output_latch[`PDEO_PE_SCL]) |
                        porte_direction[`PDEO_PE_SCL];
        if (serial_if_twowire_mode) begin
            // Open drain: drive only a low, never a high, and no pull-up.
            e_pu_next[`PDEO_PE_SDA]  = `PDEO_BIT_ZERO;
            e_oe_next[`PDEO_PE_SDA]  = sda_drive_low;
            e_out_next[`PDEO_PE_SDA] = `PDEO_BIT_ZERO;
            e_pu_next[`PDEO_PE_SCL]  = `PDEO_BIT_ZERO;
            e_oe_next[`PDEO_PE_SCL]  = scl_drive_low;
            e_out_next[`PDEO_PE_SCL] = `PDEO_BIT_ZERO;
        end

        if (usart_sync_mode && porte_direction[`PDEO_PE_XCK]) begin
            e_out_next[`PDEO_PE_XCK] = usart_sync_clock_out;
        end

        if (usart_transmitter_enable) begin
            e_oe_next[`PDEO_PE_TXD]  = `PDEO_BIT_ONE;
            e_out_next[`PDEO_PE_TXD] = usart_tx_data;
            e_pu_next[`PDEO_PE_TXD]  = `PDEO_BIT_ZERO;
        end

        if (usart_receiver_enable) begin
            e_oe_next[`PDEO_PE_RXD]  = `PDEO_BIT_ZERO;
            e_out_next[`PDEO_PE_RXD] = `PDEO_BIT_ZERO;
            e_pu_next[`PDEO_PE_RXD]  = porte_output_latch[`PDEO_PE_RXD] &
                                       ~global_pullup_disable;
        end
    end

    // Registered pin drive; the clock pin is combinational so the clock is not
    // resampled by its own edges.
    reg [7:0] e_out_reg;
    reg [7:0] e_oe_reg;

    always @(posedge clk) begin
        if (rst) begin
            portd_pin_out   <= `PDEO_PAIR_ZERO;
            portd_pin_oe    <= `PDEO_PAIR_ZERO;
            portd_pullup_en <= `PDEO_PAIR_ZERO;
            e_out_reg       <= `PDEO_BYTE_ZERO;
            e_oe_reg        <= `PDEO_BYTE_ZERO;
            porte_pullup_en <= `PDEO_BYTE_ZERO;
        end else begin
            portd_pin_out   <= d_out_next;
            portd_pin_oe    <= d_oe_next;
            portd_pullup_en <= d_pu_next;
            e_out_reg       <= e_out_next;
            e_oe_reg        <= e_oe_next;
            porte_pullup_en <= e_pu_next;
        end
    end

    // ------------------------------------------------------------
    // Divided clock output
    // ------------------------------------------------------------
    // Reset does not gate this path, so the clock keeps running during reset.
    wire divided_clock_output_active;
    assign divided_clock_output_active = clock_output_fuse;
    wire divided_clock_output_pin_out;
    wire divided_clock_output_pin_oe;
    assign divided_clock_output_pin_out = divided_clock_output_active ? divided_clock : e_out_reg[`PDEO_PE_DIVIDED_CLOCK_OUTPUT];
    assign divided_clock_output_pin_oe  = divided_clock_output_active | e_oe_reg[`PDEO_PE_DIVIDED_CLOCK_OUTPUT];

    // Final port E bit 7 drive, also visible to the pad.
    assign porte_pin_out = {divided_clock_output_pin_out, e_out_reg[6:0]};
    assign porte_pin_oe  = {divided_clock_output_pin_oe, e_oe_reg[6:0]};
endmodule
`default_nettype wire

// ===== testbench/pdeo_chk.sv
// Concurrent checks on the port D/E override outputs.
`timescale 1ns/1ns
`default_nettype none
module pdeo_chk (
    input wire       clk, rst, clock_output_fuse, usart_receiver_enable,
    input wire       global_pullup_disable, usart_transmitter_enable, usart_tx_data,
    input wire       serial_if_twowire_mode, comparator_neg_digital_disable,
    input wire       pin_change_group0_enable, external_irq_zero_enable,
    input wire       external_irq_zero_input,
    input wire [1:0] portd_direction, portd_output_latch, portd_pin_oe, portd_pin_out,
    input wire [1:0] portd_pin_in,
    input wire [7:0] porte_output_latch, porte_pin_oe, porte_pin_out, porte_pullup_en,
    input wire [7:0] porte_din, pin_change_select
);
    logic up_reg = 1'h0;
    // Registered outputs still hold reset values one edge after release, so skip it.
    always @(posedge clk) up_reg <= !rst;
    default clocking @(posedge clk); endclocking
    default disable iff (rst || !up_reg);
    AST_DIVIDED_CLOCK_OUTPUT: assert property (clock_output_fuse [*2] |-> porte_pin_oe[7])
        else $error("clock pin not driven");
    AST_RX_IN: assert property (usart_receiver_enable [*2] |-> !porte_pin_oe[0])
        else $error("receive pin driven");
    AST_RX_PU: assert property (usart_receiver_enable [*2] ##0 $stable({porte_output_latch[0],
        global_pullup_disable}) |-> porte_pullup_en[0] == (porte_output_latch[0] & !global_pullup_disable))
        else $error("receive pull-up wrong");
    AST_TX: assert property (usart_transmitter_enable [*2] ##0 $stable(usart_tx_data) |->
        porte_pin_oe[1] && !porte_pullup_en[1] && porte_pin_out[1] == usart_tx_data)
        else $error("transmit pin wrong");
    AST_TWI: assert property (serial_if_twowire_mode [*2] |->
        (porte_pullup_en[5:4] | (porte_pin_oe[5:4] & porte_pin_out[5:4])) == 2'h0)
        else $error("two-wire pin drives high");
    AST_PD: assert property ($stable({portd_direction, portd_output_latch}) |->
        portd_pin_oe == portd_direction && portd_pin_out == portd_output_latch)
        else $error("port D overridden");
    AST_CMP: assert property ((comparator_neg_digital_disable &&
        !(pin_change_select[3] && pin_change_group0_enable)) [*4] |-> !porte_din[3])
        else $error("comparator pin input on");
    AST_IRQ: assert property ((external_irq_zero_enable && portd_pin_in[1]) [*4] |->
        external_irq_zero_input)
        else $error("irq zero input lost");
endmodule
bind pdeo_port_override pdeo_chk u_chk (.*);
`default_nettype wire

// ===== testbench/pdeo_pin_model.sv
// Pad model: resolves each pin from the block drive, an outside driver and the pull-up.
`timescale 1ns/1ns
`default_nettype none
module pdeo_pin_model #(parameter W = 8) (
    input  wire          clk,
    input  wire  [W-1:0] oe, o, pu, xe, xv,
    output logic [W-1:0] p
);
    logic flip_reg = 1'h0;
    // A floating pad has no level of its own, so it toggles instead of holding one.
    always @(posedge clk) flip_reg <= !flip_reg;
    always @* for (int i = 0; i < W; i++) p[i] = oe[i] ? o[i] : xe[i] ? xv[i] : pu[i] | flip_reg;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the port D/E override block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'h0, rst = 1'h1, global_pullup_disable = 1'h0, clock_output_fuse = 1'h1;
    logic divided_clock = 1'h1, external_irq_zero_enable = 1'h0, usart_sync_mode = 1'h0;
    logic usart_sync_clock_out = 1'h0, usart_receiver_enable = 1'h0, usart_tx_data = 1'h0;
    logic usart_transmitter_enable = 1'h0, serial_if_twowire_mode = 1'h0, serial_if_sda_low = 1'h0;
    logic serial_if_threewire_mode = 1'h0, serial_if_data_out = 1'h0, serial_if_clock_hold = 1'h0;
    logic comparator_neg_digital_disable = 1'h0, comparator_pos_digital_disable = 1'h0;
    logic pin_change_group0_enable = 1'h0;
    logic [1:0] portd_direction = 2'h0, portd_output_latch = 2'h0, xd_en = 2'h0, xd_val = 2'h0;
    logic [7:0] porte_direction = 8'h00, porte_output_latch = 8'h00, pin_change_select = 8'h00;
    logic [7:0] xe_en = 8'h00, xe_val = 8'h00, porte_pin_in, porte_pin_out, porte_pin_oe;
    logic [7:0] porte_pullup_en, porte_din, pin_change_source;
    logic [1:0] portd_pin_in, portd_pin_out, portd_pin_oe, portd_pullup_en, portd_din;
    logic external_irq_zero_input, timer1_capture_input, usart_rx_input, usart_sync_clock_in;
    logic serial_if_data_in, serial_if_clock_in;
    int n_fail = 0, n_checks = 0, cyc = 0;
    always #5 clk = !clk;
    pdeo_port_override u_dut (.*);
    pdeo_pin_model #(.W(2)) u_pd (.clk(clk), .oe(portd_pin_oe), .o(portd_pin_out),
        .pu(portd_pullup_en), .xe(xd_en), .xv(xd_val), .p(portd_pin_in));
    pdeo_pin_model #(.W(8)) u_pe (.clk(clk), .oe(porte_pin_oe), .o(porte_pin_out),
        .pu(porte_pullup_en), .xe(xe_en), .xv(xe_val), .p(porte_pin_in));
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task go(input string s);
        repeat (4) @(posedge clk);
        #1 $display("test %s done", s);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            summarize;
        end
    end
    initial begin
        go("reset");
        chk("clk oe", 8'h01, porte_pin_oe[7]);
        chk("clk out", 8'h01, porte_pin_out[7]);
        repeat (4) @(posedge clk);
        {rst, divided_clock} <= 2'h0;
        go("divided_clock_output");
        chk("clk low", 8'h00, porte_pin_out[7]);
        @(posedge clk);
        {clock_output_fuse, usart_sync_mode, usart_sync_clock_out} <= 3'h3;
        porte_direction <= 8'h04;
        go("sync out");
        chk("oe7", 8'h00, porte_pin_oe[7]);
        chk("out2", 8'h01, porte_pin_out[2]);
        @(posedge clk);
        {porte_direction, xe_en, xe_val} <= 24'h000404;
        go("sync in");
        chk("xck in", 8'h01, usart_sync_clock_in);
        chk("oe2", 8'h00, porte_pin_oe[2]);
        @(posedge clk);
        {usart_sync_mode, porte_direction, xe_en} <= 17'h00400;
        go("async");
        chk("out2", 8'h00, porte_pin_out[2]);
        @(posedge clk);
        {usart_receiver_enable, porte_direction, porte_output_latch} <= 17'h10101;
        go("rx");
        chk("oe0", 8'h00, porte_pin_oe[0]);
        chk("pu0", 8'h01, porte_pullup_en[0]);
        @(posedge clk);
        global_pullup_disable <= 1'h1;
        go("rx pud");
        chk("pu0", 8'h00, porte_pullup_en[0]);
        @(posedge clk);
        {usart_receiver_enable, global_pullup_disable, usart_transmitter_enable} <= 3'h1;
        {usart_tx_data, porte_direction, porte_output_latch} <= 17'h10002;
        go("tx");
        chk("tx", 8'h03, {porte_pin_oe[1], porte_pin_out[1], porte_pullup_en[1]} >> 1);
        @(posedge clk);
        usart_tx_data <= 1'h0;
        go("tx low");
        chk("tx", 8'h04, {porte_pin_oe[1], porte_pin_out[1], porte_pullup_en[1]});
        @(posedge clk);
        {usart_transmitter_enable, serial_if_twowire_mode, serial_if_sda_low} <= 3'h3;
        {serial_if_clock_hold, porte_direction, porte_output_latch} <= 17'h13030;
        go("twi");
        chk("twi pu", 8'h00, porte_pullup_en[5:4]);
        chk("twi pin", 8'h00, porte_pin_in[5:4]);
        @(posedge clk);
        {serial_if_twowire_mode, external_irq_zero_enable, xd_en, xd_val} <= 6'h1E;
        go("port d");
        chk("irq0", 8'h01, external_irq_zero_input);
        chk("capt", 8'h00, timer1_capture_input);
        chk("pd oe", 8'h00, portd_pin_oe);
        @(posedge clk);
        xd_val <= 2'h1;
        go("capture");
        chk("d in", 8'h01, {external_irq_zero_input, timer1_capture_input});
        @(posedge clk);
        {porte_direction, pin_change_group0_enable, pin_change_select} <= 17'h001FF;
        {xe_en, xe_val} <= 16'hFFA5;
        go("pin change");
        chk("pcint", 8'hA5, pin_change_source);
        @(posedge clk);
        {pin_change_select, comparator_neg_digital_disable, comparator_pos_digital_disable} <= 10'h3;
        go("cmp");
        chk("din32", 8'h00, porte_din[3:2]);
        summarize;
    end
endmodule
`default_nettype wire
